/* File: design/sigl_pkg.sv */
// Function
// - On servo-off or fault while turning, release brake output below speed threshold.
// - Brake output drops at threshold speed or programmed off-delay, whichever first.
// - Gear switch select zero always uses the first gear numerator.
// - Switching enabled: pulse block inactive uses numerator one, active numerator two.
// - Second numerator kept within 1 to 32767; one shared denominator.
// - A set force bit makes its input function permanently active.
// - A forced function ignores the state of its physical terminal.
// - Force word one: servo on, fault clear, forward limit, reverse limit.
// - Force word two: clear or speed select, pulse block, torque limits.
// - Every input terminal is debounced with a 1 to 1000 ms time.
`default_nettype none
package sigl_pkg;
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned MS_NS = 1_000_000;
  localparam int unsigned CYC_PER_MS = MS_NS / CLK_PERIOD_NS;
  localparam int unsigned BRK_DELAY_UNIT_MS = 10;

  localparam logic [7:0] ADR_BRK_SPEED = 8'h00;
  localparam logic [7:0] ADR_BRK_DELAY = 8'h04;
  localparam logic [7:0] ADR_GEAR_SEL = 8'h08;
  localparam logic [7:0] ADR_GEAR_NUM1 = 8'h0C;
  localparam logic [7:0] ADR_GEAR_NUM2 = 8'h10;
  localparam logic [7:0] ADR_GEAR_DEN = 8'h14;
  localparam logic [7:0] ADR_FORCE1 = 8'h18;
  localparam logic [7:0] ADR_FORCE2 = 8'h1C;
  localparam logic [7:0] ADR_DBC_TIME = 8'h20;
  localparam logic [7:0] ADR_STATUS = 8'h24;

  localparam logic [15:0] RST_BRK_SPEED = 16'h001E;
  localparam logic [15:0] RST_BRK_DELAY = 16'h0014;
  localparam logic RST_GEAR_SEL = 1'b0;
  localparam logic [15:0] RST_GEAR = 16'h0001;
  localparam logic [3:0] RST_FORCE = 4'h0;
  localparam logic [15:0] RST_DBC_TIME = 16'h000A;

  localparam logic [15:0] MIN_ONE = 16'h0001;
  localparam logic [15:0] MIN_ZERO = 16'h0000;
  localparam logic [15:0] MAX_SPEED = 16'h0BB8;
  localparam logic [15:0] MAX_BRK_DELAY = 16'h00C8;
  localparam logic [15:0] MAX_GEAR = 16'h7FFF;
  localparam logic [15:0] MAX_DBC_TIME = 16'h03E8;

  typedef enum logic [1:0] {BRK_HELD, BRK_RUN, BRK_STOP} sigl_brk_state_t;

  function automatic logic [15:0] sigl_clamp(input logic [15:0] v, input logic [15:0] lo,
                                             input logic [15:0] hi);
    logic [15:0] r;
    r = v;
    if (v < lo) begin
      r = lo;
    end else if (v > hi) begin
      r = hi;
    end
    return r;
  endfunction

  // Registers are at most 16 bits wide, so only the two low byte lanes matter.
  function automatic logic [15:0] sigl_merge(input logic [15:0] old, input logic [31:0] dat,
                                             input logic [3:0] sel);
    logic [15:0] r;
    r = old;
    if (sel[0]) begin
      r[7:0] = dat[7:0];
    end
    if (sel[1]) begin
      r[15:8] = dat[15:8];
    end
    return r;
  endfunction
endpackage
`default_nettype wire

/* File: design/sigl_dbc_if.sv */
`default_nettype none
interface sigl_dbc_if;
  logic [7:0] raw;
  logic [9:0] time_ms;
  logic tick;
  logic [7:0] filt;
  modport owner (output raw, output time_ms, output tick, input filt);
  modport filter (input raw, input time_ms, input tick, output filt);
endinterface
`default_nettype wire

/* File: design/sigl_debounce.sv */
`default_nettype none
module sigl_debounce
  import sigl_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  sigl_dbc_if.filter dbc
);
  logic [7:0] s1_q;
  logic [7:0] s2_q;
  logic [7:0] filt_q;
  logic [7:0] filt_d;
  logic [10:0] cnt_q [8];
  logic [10:0] cnt_d [8];

  // The count runs on the shared millisecond tick; time plus one ticks guarantees the full time.
  always_comb begin
    filt_d = filt_q;
    for (int i = 0; i < 8; i++) begin
      cnt_d[i] = cnt_q[i];
      if (s2_q[i] == filt_q[i]) begin
        cnt_d[i] = '0;
      end else if (dbc.tick) begin
        if (cnt_q[i] >= {1'b0, dbc.time_ms}) begin
          filt_d[i] = s2_q[i];
          cnt_d[i] = '0;
        end else begin
          cnt_d[i] = cnt_q[i] + 11'h001;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_q <= '0;
      s2_q <= '0;
      filt_q <= '0;
      for (int i = 0; i < 8; i++) begin
        cnt_q[i] <= '0;
      end
    end else begin
      s1_q <= dbc.raw;
      s2_q <= s1_q;
      filt_q <= filt_d;
      for (int i = 0; i < 8; i++) begin
        cnt_q[i] <= cnt_d[i];
      end
    end
  end

  assign dbc.filt = filt_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_dbc_agree;
    (filt_q != $past(filt_q)) |-> ((filt_q ^ $past(filt_q)) & ~($past(s2_q) ^ $past(filt_q))) == 0;
  endproperty
  a_dbc_agree: assert property (p_dbc_agree) else $error("Input flipped against synced level.");

  property p_dbc_tick;
    (filt_q != $past(filt_q)) |-> $past(dbc.tick);
  endproperty
  a_dbc_tick: assert property (p_dbc_tick) else $error("Input flipped without a tick.");
endmodule
`default_nettype wire

/* File: design/sigl_brake.sv */
`default_nettype none
module sigl_brake
  import sigl_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic tick_i,
  input wire logic servo_on_i,
  input wire logic fault_i,
  input wire logic [15:0] speed_i,
  input wire logic [15:0] thr_i,
  input wire logic [15:0] delay_i,
  output logic brake_o,
  output logic stopping_o
);
  sigl_brk_state_t state_q;
  sigl_brk_state_t state_d;
  logic [11:0] cnt_q;
  logic [11:0] cnt_d;
  logic [11:0] lim;
  logic brake_q;
  logic brake_d;
  logic stop_req;

  assign lim = delay_i[11:0] * 12'(BRK_DELAY_UNIT_MS);
  assign stop_req = !servo_on_i || fault_i;

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    unique case (state_q)
      BRK_HELD: begin
        cnt_d = '0;
        if (!stop_req) begin
          state_d = BRK_RUN;
        end
      end
      BRK_RUN: begin
        cnt_d = '0;
        if (stop_req) begin
          state_d = (speed_i < thr_i) ? BRK_HELD : BRK_STOP;
        end
      end
      BRK_STOP: begin
        if (speed_i < thr_i || cnt_q >= lim) begin
          state_d = BRK_HELD;
        end else if (tick_i) begin
          cnt_d = cnt_q + 12'h001;
        end
      end
    endcase
    brake_d = (state_d != BRK_HELD);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= BRK_HELD;
      cnt_q <= '0;
      brake_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      brake_q <= brake_d;
    end
  end

  assign brake_o = brake_q;
  assign stopping_o = (state_q == BRK_STOP);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_stop_req;
    state_q == BRK_RUN && stop_req;
  endsequence

  property p_stop_entry;
    s_stop_req |=> state_q != BRK_RUN;
  endproperty
  a_stop_entry: assert property (p_stop_entry) else $error("Stop request not acted on.");

  property p_speed_release;
    (state_q == BRK_STOP && speed_i < thr_i) |=> !brake_q;
  endproperty
  a_speed_release: assert property (p_speed_release) else $error("Brake held past speed.");

  property p_delay_release;
    (state_q == BRK_STOP && cnt_q >= lim) |=> !brake_q;
  endproperty
  a_delay_release: assert property (p_delay_release) else $error("Brake held past delay.");

  property p_stop_hold;
    (state_q == BRK_STOP && speed_i >= thr_i && cnt_q < lim) |=> brake_q;
  endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("Brake dropped too early.");
endmodule
`default_nettype wire

/* File: design/sigl_top.sv */
`default_nettype none
module sigl_top
  import sigl_pkg::*;
#(
  parameter int unsigned CYCLES_PER_MS = CYC_PER_MS
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [7:0] terminal_i,
  input wire logic fault_i,
  input wire logic [15:0] feedback_speed_i,
  output logic holding_brake_out_o,
  output logic [3:0] func_word1_o,
  output logic [3:0] func_word2_o,
  output logic [15:0] gear_num_o,
  output logic [15:0] gear_den_o
);
  sigl_dbc_if dbc ();

  logic [15:0] brk_speed_q;
  logic [15:0] brk_speed_d;
  logic [15:0] brk_delay_q;
  logic [15:0] brk_delay_d;
  logic gear_sel_q;
  logic gear_sel_d;
  logic [15:0] num1_q;
  logic [15:0] num1_d;
  logic [15:0] num2_q;
  logic [15:0] num2_d;
  logic [15:0] den_q;
  logic [15:0] den_d;
  logic [3:0] force1_q;
  logic [3:0] force1_d;
  logic [3:0] force2_q;
  logic [3:0] force2_d;
  logic [15:0] dbc_time_q;
  logic [15:0] dbc_time_d;
  logic ack_q;
  logic ack_d;
  logic [31:0] dat_q;
  logic [31:0] dat_d;
  logic [31:0] status;
  logic req;
  logic [7:0] adr;

  logic [31:0] tick_cnt_q;
  logic [31:0] tick_cnt_d;
  logic tick_q;
  logic tick_d;

  logic [3:0] func1_q;
  logic [3:0] func1_d;
  logic [3:0] func2_q;
  logic [3:0] func2_d;
  logic [15:0] gnum_q;
  logic [15:0] gnum_d;
  logic [15:0] gden_q;
  logic [15:0] gden_d;
  logic brake;
  logic stopping;

  // Millisecond tick shared by the debounce bank and the brake off-delay.
  // It free-runs, so every timed wait here is granular to one tick; a debounce may end a tick late, the off-delay a tick early.
  always_comb begin
    tick_d = 1'b0;
    tick_cnt_d = tick_cnt_q + 32'h0000_0001;
    if (tick_cnt_q >= 32'(CYCLES_PER_MS - 1)) begin
      tick_cnt_d = '0;
      tick_d = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_cnt_q <= '0;
      tick_q <= 1'b0;
    end else begin
      tick_cnt_q <= tick_cnt_d;
      tick_q <= tick_d;
    end
  end

  // Wishbone slave: one wait state, every access acknowledged, unmapped reads return zero.
  assign req = wb_cyc_i && wb_stb_i && !ack_q;
  assign adr = {wb_adr_i[7:2], 2'b00};
  assign status = {22'h00_0000, stopping, gear_sel_q && func2_q[1], func2_q, func1_q};

  always_comb begin
    brk_speed_d = brk_speed_q;
    brk_delay_d = brk_delay_q;
    gear_sel_d = gear_sel_q;
    num1_d = num1_q;
    num2_d = num2_q;
    den_d = den_q;
    force1_d = force1_q;
    force2_d = force2_q;
    dbc_time_d = dbc_time_q;
    ack_d = req;
    dat_d = '0;
    if (req && wb_we_i) begin
      unique case (adr)
        ADR_BRK_SPEED: begin
          brk_speed_d = sigl_clamp(sigl_merge(brk_speed_q, wb_dat_i, wb_sel_i), MIN_ZERO, MAX_SPEED);
        end
        ADR_BRK_DELAY: begin
          brk_delay_d = sigl_clamp(sigl_merge(brk_delay_q, wb_dat_i, wb_sel_i), MIN_ZERO,
                                   MAX_BRK_DELAY);
        end
        ADR_GEAR_SEL: begin
          if (wb_sel_i[0]) begin
            gear_sel_d = wb_dat_i[0];
          end
        end
        ADR_GEAR_NUM1: begin
          num1_d = sigl_clamp(sigl_merge(num1_q, wb_dat_i, wb_sel_i), MIN_ONE, MAX_GEAR);
        end
        ADR_GEAR_NUM2: begin
          num2_d = sigl_clamp(sigl_merge(num2_q, wb_dat_i, wb_sel_i), MIN_ONE, MAX_GEAR);
        end
        ADR_GEAR_DEN: begin
          den_d = sigl_clamp(sigl_merge(den_q, wb_dat_i, wb_sel_i), MIN_ONE, MAX_GEAR);
        end
        ADR_FORCE1: begin
          if (wb_sel_i[0]) begin
            force1_d = wb_dat_i[3:0];
          end
        end
        ADR_FORCE2: begin
          if (wb_sel_i[0]) begin
            force2_d = wb_dat_i[3:0];
          end
        end
        ADR_DBC_TIME: begin
          dbc_time_d = sigl_clamp(sigl_merge(dbc_time_q, wb_dat_i, wb_sel_i), MIN_ONE,
                                  MAX_DBC_TIME);
        end
        default: begin
        end
      endcase
    end
    if (req && !wb_we_i) begin
      unique case (adr)
        ADR_BRK_SPEED: dat_d = {16'h0000, brk_speed_q};
        ADR_BRK_DELAY: dat_d = {16'h0000, brk_delay_q};
        ADR_GEAR_SEL: dat_d = {31'h0000_0000, gear_sel_q};
        ADR_GEAR_NUM1: dat_d = {16'h0000, num1_q};
        ADR_GEAR_NUM2: dat_d = {16'h0000, num2_q};
        ADR_GEAR_DEN: dat_d = {16'h0000, den_q};
        ADR_FORCE1: dat_d = {28'h000_0000, force1_q};
        ADR_FORCE2: dat_d = {28'h000_0000, force2_q};
        ADR_DBC_TIME: dat_d = {16'h0000, dbc_time_q};
        ADR_STATUS: dat_d = status;
        default: dat_d = '0;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      brk_speed_q <= RST_BRK_SPEED;
      brk_delay_q <= RST_BRK_DELAY;
      gear_sel_q <= RST_GEAR_SEL;
      num1_q <= RST_GEAR;
      num2_q <= RST_GEAR;
      den_q <= RST_GEAR;
      force1_q <= RST_FORCE;
      force2_q <= RST_FORCE;
      dbc_time_q <= RST_DBC_TIME;
      ack_q <= 1'b0;
      dat_q <= '0;
    end else begin
      brk_speed_q <= brk_speed_d;
      brk_delay_q <= brk_delay_d;
      gear_sel_q <= gear_sel_d;
      num1_q <= num1_d;
      num2_q <= num2_d;
      den_q <= den_d;
      force1_q <= force1_d;
      force2_q <= force2_d;
      dbc_time_q <= dbc_time_d;
      ack_q <= ack_d;
      dat_q <= dat_d;
    end
  end

  assign dbc.raw = terminal_i;
  assign dbc.time_ms = dbc_time_q[9:0];
  assign dbc.tick = tick_q;

  sigl_debounce u_dbc (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .dbc(dbc.filter)
  );

  // A forced function overrides its terminal; the gear mux sees the forced level as well.
  always_comb begin
    func1_d = force1_q | dbc.filt[3:0];
    func2_d = force2_q | dbc.filt[7:4];
    gden_d = den_q;
    gnum_d = num1_q;
    if (gear_sel_q && func2_q[1]) begin
      gnum_d = num2_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      func1_q <= '0;
      func2_q <= '0;
      gnum_q <= RST_GEAR;
      gden_q <= RST_GEAR;
    end else begin
      func1_q <= func1_d;
      func2_q <= func2_d;
      gnum_q <= gnum_d;
      gden_q <= gden_d;
    end
  end

  // Servo-on comes from the effective word, so a forced enable also releases the brake.
  sigl_brake u_brake (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_i(tick_q),
    .servo_on_i(func1_q[0]),
    .fault_i(fault_i),
    .speed_i(feedback_speed_i),
    .thr_i(brk_speed_q),
    .delay_i(brk_delay_q),
    .brake_o(brake),
    .stopping_o(stopping)
  );

  assign wb_dat_o = dat_q;
  assign wb_ack_o = ack_q;
  assign holding_brake_out_o = brake;
  assign func_word1_o = func1_q;
  assign func_word2_o = func2_q;
  assign gear_num_o = gnum_q;
  assign gear_den_o = gden_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_wb_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence

  property p_wb_ack;
    s_wb_req |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_wb_ack: assert property (p_wb_ack) else $error("Bus answer not one cycle after request.");

  property p_force_one;
    force1_q != 0 |=> (func_word1_o & $past(force1_q)) == $past(force1_q);
  endproperty
  a_force_one: assert property (p_force_one) else $error("Forced word one bit inactive.");

  property p_force_two;
    force2_q != 0 |=> (func_word2_o & $past(force2_q)) == $past(force2_q);
  endproperty
  a_force_two: assert property (p_force_two) else $error("Forced word two bit inactive.");

  property p_unforced;
    (force1_q == 0 && dbc.filt[3:0] == 0) |=> func_word1_o == 0;
  endproperty
  a_unforced: assert property (p_unforced) else $error("Unforced idle input active.");

  property p_gear_fixed;
    !gear_sel_q |=> gear_num_o == $past(num1_q);
  endproperty
  a_gear_fixed: assert property (p_gear_fixed) else $error("Gear switched while disabled.");

  property p_gear_switch;
    (gear_sel_q && func2_q[1]) |=> gear_num_o == $past(num2_q) && gear_den_o == $past(den_q);
  endproperty
  a_gear_switch: assert property (p_gear_switch) else $error("Second gear not chosen.");

  property p_num2_range;
    num2_q >= MIN_ONE && num2_q <= MAX_GEAR;
  endproperty
  a_num2_range: assert property (p_num2_range) else $error("Second numerator out of range.");

  property p_dbc_range;
    dbc_time_q >= MIN_ONE && dbc_time_q <= MAX_DBC_TIME;
  endproperty
  a_dbc_range: assert property (p_dbc_range) else $error("Debounce time out of range.");

  property p_rd_idle;
    !wb_ack_o |-> wb_dat_o == 32'h0000_0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("Read data shown without an answer.");
endmodule
`default_nettype wire

/* File: sim/sigl_ctrl_model.sv */
`default_nettype none
module sigl_ctrl_model (
  input wire logic clk_i,
  input wire logic [7:0] level_i,
  input wire logic [7:0] chatter_i,
  output logic [7:0] terminal_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] lfsr_q = 8'h5A;
  always @(posedge clk_i) begin
    lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
  end
  // Contacts bounce only where the bench asks; the controller has no path to the gains.
  assign terminal_o = level_i ^ (chatter_i & lfsr_q);
endmodule
`default_nettype wire

/* File: sim/testbench.sv */
`default_nettype none
module testbench
  import sigl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CPM = 20;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic req = 1'b0;
  logic we = 1'b0;
  logic fault = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [3:0] lanes = 4'h3;
  logic [31:0] wdat = 32'h0000_0000;
  logic [15:0] speed = 16'h0000;
  logic [7:0] level = 8'h00;
  logic [7:0] chatter = 8'h00;
  logic [31:0] rdat;
  logic ack, brake;
  logic [3:0] fw1, fw2;
  logic [15:0] gnum, gden;
  logic [7:0] term;
  logic [8:0] obs;
  int n_errors = 0;
  int checked = 0;

  logic [7:0] ca [3] = '{ADR_BRK_SPEED, ADR_GEAR_NUM2, ADR_DBC_TIME};
  logic [15:0] clo [3] = '{MIN_ZERO, MIN_ONE, MIN_ONE};
  logic [15:0] chi [3] = '{MAX_SPEED, MAX_GEAR, MAX_DBC_TIME};

  assign obs = {brake, fw2, fw1};

  sigl_top #(.CYCLES_PER_MS(CPM)) i_sigl_top (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .terminal_i(term),
    .fault_i(fault), .feedback_speed_i(speed), .holding_brake_out_o(brake),
    .func_word1_o(fw1), .func_word2_o(fw2), .gear_num_o(gnum), .gear_den_o(gden));

  sigl_ctrl_model i_sigl_ctrl_model (.clk_i(clk_i), .level_i(level), .chatter_i(chatter),
    .terminal_o(term));

  initial begin
    forever #2.5 clk_i = ~clk_i;
  end

  task automatic give_verdict();
    if (n_errors == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic expire(input string nm);
    n_errors++;
    $display("[ERR] %s expected answer seen none", nm);
    give_verdict();
  endtask

  // Holds the request until ack is seen at an edge, then idles one cycle.
  task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d,
                    output logic [31:0] r);
    int n;
    n = 0;
    req <= 1'b1;
    we <= w;
    adr <= a;
    sel <= lanes;
    wdat <= {16'h0000, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 16);
    if (ack !== 1'b1) begin
      expire("wb_ack_o");
    end
    r = rdat;
    req <= 1'b0;
    we <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [31:0] r;
    wb(1'b1, a, d, r);
  endtask

  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    wb(1'b0, a, 16'h0000, r);
    chk(nm, e, r);
  endtask

  task automatic wfor(input int b, input logic v, input int lim, output int n);
    n = 0;
    while (obs[b] !== v && n < lim) begin
      @(posedge clk_i);
      n++;
    end
    if (obs[b] !== v) begin
      expire("watched output");
    end
  endtask

  function automatic logic [15:0] lim(input logic [15:0] v, input logic [15:0] lo,
                                      input logic [15:0] hi);
    return (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  initial begin
    int n;
    int b;
    int t;
    logic [15:0] v;
    logic [7:0] a;
    void'($urandom(4796));
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk("gear_num_o", 32'h0000_0001, {16'h0000, gnum});
    rdc("speed", ADR_BRK_SPEED, {16'h0000, RST_BRK_SPEED});
    rdc("delay", ADR_BRK_DELAY, {16'h0000, RST_BRK_DELAY});
    rdc("gear sel", ADR_GEAR_SEL, 32'h0000_0000);
    rdc("num2", ADR_GEAR_NUM2, 32'h0000_0001);
    rdc("force1", ADR_FORCE1, 32'h0000_0000);
    rdc("force2", ADR_FORCE2, 32'h0000_0000);
    rdc("dbc", ADR_DBC_TIME, {16'h0000, RST_DBC_TIME});
    rdc("unmapped", 8'h30, 32'h0000_0000);
    for (int i = 0; i < 15; i++) begin
      v = (i < 6) ? {16{i[0]}} : 16'($urandom);
      wr(ca[i % 3], v);
      rdc("clamp", ca[i % 3], {16'h0000, lim(v, clo[i % 3], chi[i % 3])});
    end
    lanes = 4'h0;
    wr(ADR_FORCE1, 16'h000F);
    lanes = 4'h3;
    rdc("force1 no lane", ADR_FORCE1, 32'h0000_0000);
    wr(ADR_DBC_TIME, 16'h0002);
    for (int i = 0; i < 8; i++) begin
      a = (i < 4) ? ADR_FORCE1 : ADR_FORCE2;
      wr(a, 16'(1 << (i % 4)));
      chatter[i] <= 1'b1;
      repeat (30) @(posedge clk_i);
      chk("forced", 32'(1 << i), {23'h0, obs}  & 32'h0000_00FF);
      chatter[i] <= 1'b0;
      wr(a, 16'h0000);
      repeat (2) @(posedge clk_i);
      chk("unforced", 32'h0000_0000, {24'h0, fw2, fw1});
    end
    for (int k = 0; k < 5; k++) begin
      t = 1 + $urandom % 3;
      b = $urandom % 8;
      wr(ADR_DBC_TIME, 16'(t));
      v[0] = ~level[b];
      level[b] <= v[0];
      chatter[b] <= 1'b1;
      repeat (20) @(posedge clk_i);
      chk("bouncing", 32'(!v[0]), 32'(obs[b]));
      chatter[b] <= 1'b0;
      level[b] <= !v[0];
      repeat (4) @(posedge clk_i);
      level[b] <= v[0];
      wfor(b, v[0], (t + 1) * CPM + 10, n);
      chk("held time", 32'h0000_0001, 32'(n >= t * CPM));
    end
    level <= 8'h00;
    repeat (100) @(posedge clk_i);
    wr(ADR_GEAR_NUM1, 16'h0005);
    wr(ADR_GEAR_NUM2, 16'h0009);
    wr(ADR_GEAR_DEN, 16'h0007);
    for (int s = 0; s < 4; s++) begin
      wr(ADR_GEAR_SEL, 16'(s[1]));
      wr(ADR_FORCE2, {14'h0000, s[0], 1'b0});
      repeat (3) @(posedge clk_i);
      chk("gear_num_o", (s == 3) ? 32'h0000_0009 : 32'h0000_0005, {16'h0, gnum});
      chk("gear_den_o", 32'h0000_0007, {16'h0000, gden});
      rdc("status", ADR_STATUS, {22'h0, 1'b0, 1'(s == 3), 2'b00, s[0], 5'h00});
    end
    wr(ADR_FORCE2, 16'h0000);
    wr(ADR_BRK_SPEED, 16'h01F4);
    for (int m = 0; m < 3; m++) begin
      speed <= 16'h03E8;
      wr(ADR_BRK_DELAY, (m == 2) ? 16'h0000 : 16'h0001);
      wr(ADR_FORCE1, 16'h0001);
      wfor(8, 1'b1, 10, n);
      if (m == 1) begin
        fault <= 1'b1;
      end else begin
        wr(ADR_FORCE1, 16'h0000);
      end
      if (m == 0) begin
        repeat (60) @(posedge clk_i);
        chk("brake fast", 32'h0000_0001, {31'h0, brake});
        rdc("status", ADR_STATUS, 32'h0000_0200);
        speed <= 16'h0064;
      end
      wfor(8, 1'b0, (m == 1) ? 260 : 4, n);
      if (m == 1) begin
        chk("off delay", 32'h0000_0001, 32'(n >= 9 * CPM - 5 && n <= 10 * CPM + 10));
      end
      fault <= 1'b0;
    end
    give_verdict();
  end
endmodule
`default_nettype wire
